// *** pkg/opt_cfg_defs.svh ***
// Offsets, field positions, reset values and sizes of the option byte block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef OPT_CFG_DEFS_SVH
`define OPT_CFG_DEFS_SVH

// Register byte offsets on the Wishbone slave
`define OFS_OPT0        8'h00
`define OFS_OPT1        8'h04
`define OFS_MEM_ADDR    8'h08
`define OFS_MEM_DATA    8'h0C
`define OFS_CMD         8'h10
`define OFS_STATUS      8'h14
`define OFS_APPLIED     8'h18

// Option byte 1 fields
`define OPT1_CLK_HI     7
`define OPT1_CLK_LO     6
`define OPT1_VDET_OFF   2
`define OPT1_WDG_SOFT   1
`define OPT1_WATCHDOG_HALT_RESET   0

// Option byte 0 fields
`define OPT0_SECTOR_HI  3
`define OPT0_SECTOR_LO  2
`define OPT0_RDP        1
`define OPT0_WRP        0

// Erased / delivered option byte values
`define OPT0_DEFAULT    8'hF0
`define OPT1_DEFAULT    8'h2F

// Start-up clock codes
`define CLK_INTERNAL_RC 2'h0
`define CLK_EXTERNAL    2'h3

// Sector 0 sizes in bytes
`define SECTOR_SIZE_HALF_K 12'h200
`define SECTOR_SIZE_1K     12'h400
`define SECTOR_SIZE_2K     12'h800

// Command register bits
`define CMD_ERASE_MEM   0
`define CMD_ERASE_OPT   1
`define CMD_CLR_REFUSED 2

// Status register bits
`define STS_PROG_MODE   0
`define STS_BUSY        1
`define STS_REFUSED     2
`define STS_RDP         3
`define STS_WRP         4

// Program memory
`define MEM_DEPTH       2048
`define MEM_AW          11
`define ERASED_BYTE     8'hFF

`endif

// *** pkg/opt_cfg_pkg.sv ***
// Types of the option byte configuration block.
// Assumes the defines header is on the include path.
`include "opt_cfg_defs.svh"

package opt_cfg_pkg;

  typedef enum logic [2:0] {
    ERS_IDLE = 3'b001,
    ERS_MEM  = 3'b010,
    ERS_OPT  = 3'b100
  } erase_state_e;

  typedef struct packed {
    logic [1:0]  clk_sel;
    logic        use_rc;
    logic        use_ext;
    logic        vdet_en;
    logic        wdg_hw;
    logic        wdg_soft;
    logic        watchdog_halt_reset_rst;
    logic [11:0] sector0_bytes;
    logic        rdp;
    logic        wrp;
  } cfg_s;

  typedef struct packed {
    logic         prog_meta;
    logic         prog_sync;
    logic [7:0]   opt0;
    logic [7:0]   opt1;
    cfg_s         cfg;
    erase_state_e fsm;
    logic         erase_opt;
    logic         ack;
    logic [31:0]  dat;
    logic [10:0]  mem_addr;
    logic         refused;
    logic         halt_rst;
  } top_state_s;

  typedef struct packed {
    logic [`MEM_DEPTH-1:0][7:0] bytes;
  } mem_state_s;

endpackage

// *** rtl/prog_memory.sv ***
// Program memory array with byte write, whole erase and combinational read.
// Assumes the caller has already applied all protection checks.
`timescale 1ns/10ps
`default_nettype none
`include "opt_cfg_defs.svh"

module prog_memory (
  input  wire logic                clk_i,      // System clock
  input  wire logic                pwr_on_ni,  // Power-on reset, active low
  input  wire logic [`MEM_AW-1:0]  addr_i,     // Byte address
  input  wire logic                wr_en_i,    // Program one byte
  input  wire logic [7:0]          wr_data_i,  // Byte to program
  input  wire logic                erase_i,    // Erase whole array
  output logic      [7:0]          rd_data_o   // Byte at addr_i
);

  opt_cfg_pkg::mem_state_s q;
  opt_cfg_pkg::mem_state_s d;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    if (erase_i) begin
      d.bytes = {`MEM_DEPTH{`ERASED_BYTE}};
    end else if (wr_en_i) begin
      d.bytes[addr_i] = wr_data_i;
    end
  end

  // ==========================================================
  // Delivered content is all erased bytes
  always_ff @(posedge clk_i) begin
    if (!pwr_on_ni) begin
      q.bytes <= {`MEM_DEPTH{`ERASED_BYTE}};
    end else begin
      q <= d;
    end
  end

  assign rd_data_o = q.bytes[addr_i];

endmodule
`default_nettype wire

// *** rtl/option_byte_config_decoder.sv ***
// Option byte store, decoder and program memory guard with a Wishbone slave.
// Assumes clk_i at 50 MHz, synchronous resets and a classic Wishbone master.
// prog_mode_i comes from a pin; halt_entry_i and watchdog_running_i come from
// core logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "opt_cfg_defs.svh"

module option_byte_config_decoder (
  input  wire logic        clk_i,                        // System clock
  input  wire logic        nrst_i,                       // System reset, active low
  input  wire logic        pwr_on_ni,                    // Power-on reset, active low
  input  wire logic        wb_cyc_i,                     // Wishbone cycle
  input  wire logic        wb_stb_i,                     // Wishbone strobe
  input  wire logic        wb_we_i,                      // Wishbone write
  input  wire logic [7:0]  wb_adr_i,                     // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,                     // Wishbone byte select
  input  wire logic [31:0] wb_dat_i,                     // Wishbone write data
  output logic      [31:0] wb_dat_o,                     // Wishbone read data
  output logic             wb_ack_o,                     // Wishbone acknowledge
  input  wire logic        prog_mode_i,                  // Programming mode pin
  input  wire logic        halt_entry_i,                 // Core enters halt, pulse
  input  wire logic        watchdog_running_i,           // Software started watchdog
  output logic      [1:0]  startup_clock_select_o,       // Raw start-up clock code
  output logic             internal_rc_select_o,         // Start on internal RC
  output logic             external_clock_pin_select_o,  // Start on external clock pin
  output logic             low_voltage_detect_enable_o,  // Voltage detector on
  output logic             watchdog_hw_enable_o,         // Watchdog always on
  output logic             watchdog_soft_enable_o,       // Watchdog started by software
  output logic             watchdog_halt_reset_o,        // Halt reset option
  output logic             halt_reset_req_o,             // Reset request, pulse
  output logic      [11:0] sector0_size_o,               // Sector 0 size in bytes
  output logic             readout_protect_o,            // Readout protection applied
  output logic             write_protect_permanent_o     // Write protection applied
);

  // ==========================================================
  // Option byte decoding
  function automatic opt_cfg_pkg::cfg_s decode_cfg(input logic [7:0] b0, input logic [7:0] b1);
    opt_cfg_pkg::cfg_s c;
    c = '0;
    c.clk_sel      = b1[`OPT1_CLK_HI:`OPT1_CLK_LO];
    c.use_rc       = (b1[`OPT1_CLK_HI:`OPT1_CLK_LO] == `CLK_INTERNAL_RC);
    c.use_ext      = (b1[`OPT1_CLK_HI:`OPT1_CLK_LO] == `CLK_EXTERNAL);
    c.vdet_en      = ~b1[`OPT1_VDET_OFF];
    c.wdg_hw       = ~b1[`OPT1_WDG_SOFT];
    c.wdg_soft     = b1[`OPT1_WDG_SOFT];
    c.watchdog_halt_reset_rst = b1[`OPT1_WATCHDOG_HALT_RESET];
    // Low size bit set wins over the high one
    if (b0[`OPT0_SECTOR_LO]) begin
      c.sector0_bytes = `SECTOR_SIZE_2K;
    end else if (b0[`OPT0_SECTOR_HI]) begin
      c.sector0_bytes = `SECTOR_SIZE_1K;
    end else begin
      c.sector0_bytes = `SECTOR_SIZE_HALF_K;
    end
    c.rdp          = b0[`OPT0_RDP];
    c.wrp          = b0[`OPT0_WRP];
    return c;
  endfunction

  opt_cfg_pkg::top_state_s q;
  opt_cfg_pkg::top_state_s d;

  logic       hit;
  logic       in_prog;
  logic       idle;
  logic       rdp_eff;
  logic       wrp_eff;
  logic       set_refused;
  logic       clr_refused;
  logic       mem_wr;
  logic       mem_erase;
  logic [7:0] mem_rd;
  logic [7:0] nv0;

  // ==========================================================
  // Program memory
  prog_memory u_mem (
    .clk_i     (clk_i),
    .pwr_on_ni (pwr_on_ni),
    .addr_i    (q.mem_addr),
    .wr_en_i   (mem_wr),
    .wr_data_i (wb_dat_i[7:0]),
    .erase_i   (mem_erase),
    .rd_data_o (mem_rd)
  );

  // ==========================================================
  // Next state
  always_comb begin
    d           = q;
    nv0         = q.opt0;
    set_refused = 1'b0;
    clr_refused = 1'b0;
    mem_wr      = 1'b0;
    mem_erase   = 1'b0;
    // Mode pin passes two flops before anything reads it
    d.prog_meta = prog_mode_i;
    d.prog_sync = q.prog_meta;
    d.ack       = 1'b0;
    d.dat       = 32'h0;
    d.halt_rst  = 1'b0;

    hit     = wb_cyc_i & wb_stb_i & ~q.ack;
    in_prog = q.prog_sync;
    idle    = (q.fsm == opt_cfg_pkg::ERS_IDLE);
    // Protection takes effect at once, not only after the next reset
    rdp_eff = q.opt0[`OPT0_RDP] | q.cfg.rdp;
    wrp_eff = q.opt0[`OPT0_WRP] | q.cfg.wrp;

    // Erase sequencer
    // Memory goes first so protected code never outlives its options
    case (q.fsm)
      opt_cfg_pkg::ERS_IDLE: begin
        d.fsm = opt_cfg_pkg::ERS_IDLE;
      end
      opt_cfg_pkg::ERS_MEM: begin
        mem_erase = 1'b1;
        d.fsm     = q.erase_opt ? opt_cfg_pkg::ERS_OPT : opt_cfg_pkg::ERS_IDLE;
      end
      opt_cfg_pkg::ERS_OPT: begin
        d.opt0      = `OPT0_DEFAULT;
        d.opt1      = `OPT1_DEFAULT;
        d.erase_opt = 1'b0;
        d.fsm       = opt_cfg_pkg::ERS_IDLE;
      end
      default: begin
        d.fsm = opt_cfg_pkg::ERS_IDLE;
      end
    endcase

    // Halt entry with an active watchdog
    d.halt_rst = halt_entry_i & (watchdog_running_i | q.cfg.wdg_hw) & q.cfg.watchdog_halt_reset_rst;

    // Wishbone slave: one wait state, ack for one cycle
    if (hit) begin
      d.ack = 1'b1;
      d.dat = 32'h0;
      if (wb_we_i) begin
        if (wb_adr_i == `OFS_OPT0) begin
          if (in_prog && idle && wb_sel_i[0]) begin
            // Protection bits can be set here but never cleared
            nv0 = wb_dat_i[7:0];
            if (wrp_eff && !nv0[`OPT0_WRP]) begin
              nv0[`OPT0_WRP] = 1'b1;
              set_refused    = 1'b1;
            end
            if (rdp_eff && !nv0[`OPT0_RDP]) begin
              nv0[`OPT0_RDP] = 1'b1;
              set_refused    = 1'b1;
            end
            d.opt0 = nv0;
          end else begin
            set_refused = 1'b1;
          end
        end else if (wb_adr_i == `OFS_OPT1) begin
          if (in_prog && idle && wb_sel_i[0]) begin
            d.opt1 = wb_dat_i[7:0];
          end else begin
            set_refused = 1'b1;
          end
        end else if (wb_adr_i == `OFS_MEM_ADDR) begin
          if (wb_sel_i[0]) begin
            d.mem_addr[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            d.mem_addr[10:8] = wb_dat_i[10:8];
          end
        end else if (wb_adr_i == `OFS_MEM_DATA) begin
          if (wb_sel_i[0]) begin
            if (rdp_eff || wrp_eff || !idle) begin
              set_refused = 1'b1;
            end else begin
              mem_wr = 1'b1;
            end
          end
        end else if (wb_adr_i == `OFS_CMD) begin
          if (wb_sel_i[0]) begin
            clr_refused = wb_dat_i[`CMD_CLR_REFUSED];
            if (wb_dat_i[`CMD_ERASE_OPT]) begin
              if (!in_prog || !idle || wrp_eff) begin
                set_refused = 1'b1;
              end else if (rdp_eff) begin
                d.erase_opt = 1'b1;
                d.fsm       = opt_cfg_pkg::ERS_MEM;
              end else begin
                d.fsm = opt_cfg_pkg::ERS_OPT;
              end
            end else if (wb_dat_i[`CMD_ERASE_MEM]) begin
              if (!idle || wrp_eff || rdp_eff) begin
                set_refused = 1'b1;
              end else begin
                d.fsm = opt_cfg_pkg::ERS_MEM;
              end
            end
          end
        end
      end else begin
        if (wb_adr_i == `OFS_OPT0) begin
          d.dat[7:0] = in_prog ? q.opt0 : 8'h00;
        end else if (wb_adr_i == `OFS_OPT1) begin
          d.dat[7:0] = in_prog ? q.opt1 : 8'h00;
        end else if (wb_adr_i == `OFS_MEM_ADDR) begin
          d.dat[10:0] = q.mem_addr;
        end else if (wb_adr_i == `OFS_MEM_DATA) begin
          d.dat[7:0] = (in_prog && rdp_eff) ? 8'h00 : mem_rd;
        end else if (wb_adr_i == `OFS_STATUS) begin
          d.dat[`STS_PROG_MODE] = in_prog;
          d.dat[`STS_BUSY]      = ~idle;
          d.dat[`STS_REFUSED]   = q.refused;
          d.dat[`STS_RDP]       = rdp_eff;
          d.dat[`STS_WRP]       = wrp_eff;
        end else if (wb_adr_i == `OFS_APPLIED) begin
          d.dat[1:0]  = q.cfg.clk_sel;
          d.dat[2]    = q.cfg.vdet_en;
          d.dat[3]    = q.cfg.wdg_soft;
          d.dat[4]    = q.cfg.watchdog_halt_reset_rst;
          d.dat[5]    = q.cfg.rdp;
          d.dat[6]    = q.cfg.wrp;
          d.dat[19:8] = q.cfg.sector0_bytes;
        end
      end
    end

    // New refusal wins over a clear in the same cycle
    d.refused = (q.refused & ~clr_refused) | set_refused;

    // System reset: latch the option bytes, then hold them static
    if (!nrst_i) begin
      d.cfg       = decode_cfg(q.opt0, q.opt1);
      d.prog_meta = 1'b0;
      d.prog_sync = 1'b0;
      d.fsm       = opt_cfg_pkg::ERS_IDLE;
      d.erase_opt = 1'b0;
      d.ack       = 1'b0;
      d.dat       = 32'h0;
      d.mem_addr  = 11'h000;
      d.refused   = 1'b0;
      d.halt_rst  = 1'b0;
      d.opt0      = q.opt0;
      d.opt1      = q.opt1;
      mem_wr      = 1'b0;
      mem_erase   = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (!pwr_on_ni) begin
      q.prog_meta <= 1'b0;
      q.prog_sync <= 1'b0;
      q.opt0      <= `OPT0_DEFAULT;
      q.opt1      <= `OPT1_DEFAULT;
      q.cfg       <= decode_cfg(`OPT0_DEFAULT, `OPT1_DEFAULT);
      q.fsm       <= opt_cfg_pkg::ERS_IDLE;
      q.erase_opt <= 1'b0;
      q.ack       <= 1'b0;
      q.dat       <= 32'h0;
      q.mem_addr  <= 11'h000;
      q.refused   <= 1'b0;
      q.halt_rst  <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  // Configuration levels change only while nrst_i or pwr_on_ni is low
  assign wb_dat_o                    = q.dat;
  assign wb_ack_o                    = q.ack;
  assign startup_clock_select_o      = q.cfg.clk_sel;
  assign internal_rc_select_o        = q.cfg.use_rc;
  assign external_clock_pin_select_o = q.cfg.use_ext;
  assign low_voltage_detect_enable_o = q.cfg.vdet_en;
  assign watchdog_hw_enable_o        = q.cfg.wdg_hw;
  assign watchdog_soft_enable_o      = q.cfg.wdg_soft;
  assign watchdog_halt_reset_o       = q.cfg.watchdog_halt_reset_rst;
  assign halt_reset_req_o            = q.halt_rst;
  assign sector0_size_o              = q.cfg.sector0_bytes;
  assign readout_protect_o           = q.cfg.rdp;
  assign write_protect_permanent_o   = q.cfg.wrp;

endmodule
`default_nettype wire

// *** tb/prog_tool_model.sv ***
// Programming tool model: drives the mode pin, shapes option bytes.
// Assumes the bench supplies raw field values on the system clock.
`timescale 1ns/10ps
`default_nettype none
module prog_tool_model (
  input  wire logic       clk_i,       // System clock
  input  wire logic       en_i,        // Enter programming mode
  input  wire logic [7:0] raw0_i,      // Wanted byte 0 fields
  input  wire logic [7:0] raw1_i,      // Wanted byte 1 fields
  output logic            prog_mode_o, // Mode pin
  output logic      [7:0] opt0_o,      // Byte 0 as written
  output logic      [7:0] opt1_o       // Byte 1 as written
);
  // ==========================================
  // Mode pin and byte forming
  always @(posedge clk_i) prog_mode_o <= en_i;
  assign opt0_o = {4'hF, raw0_i[3:0]};
  assign opt1_o = {raw1_i[7:6], 3'b101, raw1_i[2:0]};
endmodule
`default_nettype wire

// *** tb/option_byte_config_decoder_assertions.sv ***
// Port checker for the option byte decoder.
// Assumes a single clock and binding to the decoder top.
`timescale 1ns/10ps
`default_nettype none
module option_byte_config_decoder_checker (
  input wire logic        clk_i,                       // Clock
  input wire logic        nrst_i,                      // Reset
  input wire logic        pwr_on_ni,                   // Power-on reset
  input wire logic        wb_cyc_i,                    // Cycle
  input wire logic        wb_stb_i,                    // Strobe
  input wire logic        wb_ack_o,                    // Acknowledge
  input wire logic        halt_entry_i,                // Halt entry
  input wire logic        watchdog_running_i,          // Soft watchdog on
  input wire logic [1:0]  startup_clock_select_o,      // Clock code
  input wire logic        internal_rc_select_o,        // RC start
  input wire logic        external_clock_pin_select_o, // Pin start
  input wire logic        watchdog_hw_enable_o,        // Hard watchdog
  input wire logic        watchdog_soft_enable_o,      // Soft watchdog
  input wire logic        watchdog_halt_reset_o,       // Halt option
  input wire logic        halt_reset_req_o,            // Halt reset
  input wire logic [11:0] sector0_size_o               // Sector size
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i || !pwr_on_ni);
  // ==========================================
  // Bus and decode relations
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  rc_code_a: assert property (internal_rc_select_o == (startup_clock_select_o == 2'h0))
    else $error("rc select disagrees with code");
  ext_code_a: assert property (external_clock_pin_select_o == (startup_clock_select_o == 2'h3))
    else $error("pin select disagrees with code");
  wdg_type_a: assert property (watchdog_hw_enable_o == !watchdog_soft_enable_o)
    else $error("watchdog type not exclusive");
  sector_size_a: assert property (sector0_size_o inside {12'h200, 12'h400, 12'h800})
    else $error("sector size illegal");
  cfg_static_a: assert property ($past(nrst_i) && $past(pwr_on_ni) |->
    $stable({startup_clock_select_o, watchdog_soft_enable_o, watchdog_halt_reset_o, sector0_size_o}))
    else $error("configuration moved outside reset");
  halt_reset_a: assert property (halt_entry_i && watchdog_halt_reset_o &&
    (watchdog_running_i || watchdog_hw_enable_o) |=> halt_reset_req_o)
    else $error("halt reset missing");
  halt_quiet_a: assert property (!(halt_entry_i && watchdog_halt_reset_o &&
    (watchdog_running_i || watchdog_hw_enable_o)) |=> !halt_reset_req_o)
    else $error("halt reset without cause");
endmodule
bind option_byte_config_decoder option_byte_config_decoder_checker chk (
  .clk_i, .nrst_i, .pwr_on_ni, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .halt_entry_i, .watchdog_running_i,
  .startup_clock_select_o, .internal_rc_select_o, .external_clock_pin_select_o, .watchdog_hw_enable_o,
  .watchdog_soft_enable_o, .watchdog_halt_reset_o, .halt_reset_req_o, .sector0_size_o
);
`default_nettype wire

// *** tb/option_byte_config_decoder_tb.sv ***
// Self-checking bench for the option byte decoder.
// Assumes the defines header on the include path and the tool model.
`timescale 1ns/10ps
`default_nettype none
`include "opt_cfg_defs.svh"
module option_byte_config_decoder_tb;
  logic        clk_i, nrst_i, pwr_on_ni, wb_cyc_i, wb_stb_i, wb_we_i, en, halt_entry_i, watchdog_running_i;
  logic [7:0]  wb_adr_i, r0, r1;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, q, rnd;
  logic [63:0] mon_e;
  logic [2:0]  b;
  logic [1:0]  s;
  wire  [31:0] wb_dat_o;
  wire  [11:0] sector0_size_o;
  wire  [7:0]  o0, o1;
  wire  [1:0]  startup_clock_select_o;
  wire         wb_ack_o, prog_mode_i, internal_rc_select_o, external_clock_pin_select_o;
  wire         low_voltage_detect_enable_o, watchdog_hw_enable_o, watchdog_soft_enable_o;
  wire         watchdog_halt_reset_o, halt_reset_req_o, readout_protect_o, write_protect_permanent_o;
  int          num_errors, checks, seed;
  logic [63:0] expq[$];

  option_byte_config_decoder dut (.clk_i, .nrst_i, .pwr_on_ni, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .prog_mode_i, .halt_entry_i, .watchdog_running_i,
    .startup_clock_select_o, .internal_rc_select_o, .external_clock_pin_select_o,
    .low_voltage_detect_enable_o, .watchdog_hw_enable_o, .watchdog_soft_enable_o, .watchdog_halt_reset_o,
    .halt_reset_req_o, .sector0_size_o, .readout_protect_o, .write_protect_permanent_o);
  prog_tool_model tool (.clk_i, .en_i(en), .raw0_i(r0), .raw1_i(r1), .prog_mode_o(prog_mode_i),
    .opt0_o(o0), .opt1_o(o1));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ==========================================
  // Checking and bus tasks
  task results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expq.push_back({m, e});
    wb(1'b0, a, 32'h0);
  endtask
  task rst;
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  task hchk(input logic r, input logic e);
    @(posedge clk_i);
    halt_entry_i       <= 1'b1;
    watchdog_running_i <= r;
    @(posedge clk_i);
    halt_entry_i <= 1'b0;
    @(negedge clk_i);
    chk("halt reset", e, halt_reset_req_o);
  endtask
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
      mon_e = expq.pop_front();
      chk("read data", mon_e[31:0], wb_dat_o & mon_e[63:32]);
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    seed = 6;
    num_errors = 0;
    checks = 0;
    {nrst_i, pwr_on_ni, wb_cyc_i, wb_stb_i, wb_we_i, en, halt_entry_i, watchdog_running_i} = 8'h00;
    {wb_adr_i, r0, r1, wb_dat_i} = 56'h0;
    wb_sel_i = 4'h3;
    repeat (20) @(posedge clk_i);
    nrst_i    <= 1'b1;
    pwr_on_ni <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("clock code", 2'h0, startup_clock_select_o);
    chk("rc select", 1'b1, internal_rc_select_o);
    chk("voltage detect", 1'b0, low_voltage_detect_enable_o);
    chk("soft wdg", 1'b1, watchdog_soft_enable_o);
    hchk(1'b1, 1'b1);
    rnd = $random(seed) & 32'h7FF;
    wb(1'b1, `OFS_MEM_ADDR, rnd);
    rd(`OFS_MEM_ADDR, rnd, 32'h7FF);
    rd(`OFS_MEM_DATA, 32'hFF, 32'hFF);
    wb(1'b1, `OFS_OPT1, 32'h6F);
    rd(`OFS_OPT1, 32'h0, 32'hFF);
    rd(`OFS_STATUS, 32'h4, 32'h7);
    wb(1'b1, `OFS_CMD, 32'h4);
    en <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      b = rnd[2:0];
      s = rnd[5:4];
      r0 <= {4'h0, s, 2'b00};
      r1 <= {i[1:0], 3'b000, b};
      @(posedge clk_i);
      wb(1'b1, `OFS_OPT0, {24'h0, o0});
      wb(1'b1, `OFS_OPT1, {24'h0, o1});
      rd(`OFS_OPT1, {24'h0, o1}, 32'hFF);
      rst();
      chk("clock code", i[1:0], startup_clock_select_o);
      chk("rc select", i == 0, internal_rc_select_o);
      chk("ext select", i == 3, external_clock_pin_select_o);
      chk("voltage detect", !b[2], low_voltage_detect_enable_o);
      chk("hw wdg", !b[1], watchdog_hw_enable_o);
      chk("halt option", b[0], watchdog_halt_reset_o);
      chk("sector", s[0] ? 32'h800 : (s[1] ? 32'h400 : 32'h200), sector0_size_o);
      rd(`OFS_APPLIED, {12'h0, (s[0] ? 12'h800 : (s[1] ? 12'h400 : 12'h200)), 1'b0, 2'b00, b[0], b[1], !b[2],
        i[1:0]}, 32'hFFFFF);
      hchk(rnd[8], b[0] & (rnd[8] | !b[1]));
    end
    wb(1'b1, `OFS_MEM_DATA, 32'h5A);
    rd(`OFS_MEM_DATA, 32'h5A, 32'hFF);
    wb(1'b1, `OFS_CMD, 32'h1);
    rd(`OFS_MEM_DATA, 32'hFF, 32'hFF);
    wb(1'b1, `OFS_OPT0, 32'hF2);
    wb(1'b1, `OFS_MEM_DATA, 32'hA5);
    rd(`OFS_MEM_DATA, 32'h0, 32'hFF);
    rd(`OFS_STATUS, 32'hD, 32'hF);
    wb(1'b1, `OFS_CMD, 32'h6);
    repeat (3) @(posedge clk_i);
    rd(`OFS_OPT0, 32'hF0, 32'hFF);
    rd(`OFS_OPT1, 32'h2F, 32'hFF);
    rd(`OFS_MEM_DATA, 32'hFF, 32'hFF);
    wb(1'b1, `OFS_OPT0, 32'hF1);
    wb(1'b1, `OFS_OPT0, 32'hF0);
    rd(`OFS_OPT0, 32'h1, 32'h1);
    wb(1'b1, `OFS_MEM_DATA, 32'h0);
    wb(1'b1, `OFS_CMD, 32'h1);
    rd(`OFS_MEM_DATA, 32'hFF, 32'hFF);
    wb(1'b1, `OFS_CMD, 32'h2);
    repeat (3) @(posedge clk_i);
    rd(`OFS_OPT0, 32'h1, 32'h1);
    wb(1'b1, `OFS_OPT0, 32'hF3);
    rst();
    chk("readout protect", 1'b1, readout_protect_o);
    chk("write protect", 1'b1, write_protect_permanent_o);
    rd(`OFS_OPT0, 32'h3, 32'h3);
    repeat (4) @(posedge clk_i);
    results();
  end
endmodule
`default_nettype wire
